// file: verilog/interlock_pkg.sv
// Package for the safety interlock monitor: register map, field layout and timing.
// Assumes a 40 MHz APB clock; all registers are one aligned 32-bit word.
package interlock_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned DISAGREE_SEC    = 2;
  localparam int unsigned DISAGREE_CYCLES = DISAGREE_SEC * CLK_HZ;
  localparam int unsigned TIMER_W         = 27;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATE  = 12'h004;
  localparam logic [11:0] OFS_EVENT  = 12'h008;
  localparam logic [11:0] OFS_ENABLE = 12'h00C;
  localparam logic [11:0] OFS_CLEAR  = 12'h010;

  // CTRL fields (write 1 pulses).
  localparam int unsigned CTRL_RESET_CMD = 0;
  localparam int unsigned CTRL_CRIT_ACK  = 1;

  // STATE fields.
  localparam int unsigned ST_ESTOP       = 0;
  localparam int unsigned ST_HALT_LED    = 1;
  localparam int unsigned ST_GUARD_LATCH = 2;
  localparam int unsigned ST_JOG_LATCH   = 3;
  localparam int unsigned ST_PROHIBIT    = 4;
  localparam int unsigned ST_HOLD        = 5;
  localparam int unsigned ST_CRIT_GUARD  = 6;
  localparam int unsigned ST_CRIT_CKT    = 7;
  localparam int unsigned ST_CRIT_SW     = 8;
  localparam int unsigned ST_PENDANT     = 9;
  localparam int unsigned ST_MANUAL      = 10;
  localparam int unsigned ST_LINK_UP     = 11;
  localparam int unsigned ST_W           = 12;

  // EVENT fields.
  localparam int unsigned EV_ESTOP    = 0;
  localparam int unsigned EV_CRIT     = 1;
  localparam int unsigned EV_GUARD    = 2;
  localparam int unsigned EV_PENDANT  = 3;
  localparam int unsigned EV_W        = 4;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Field inputs gathered together; the monitor synchronises them but does not debounce them.
  typedef struct packed {
    logic guard_a;
    logic guard_b;
    logic ckt_a;
    logic ckt_b;
    logic sw_a;
    logic sw_b;
    logic latch_release;
    logic pendant_present;
    logic bypass_plug;
    logic mode_manual;
    logic connector_present;
  } field_in_s;

  localparam int unsigned FIELD_W = 11;

  typedef enum logic [2:0] {
    LINK_IDLE  = 3'b001,
    LINK_SETUP = 3'b010,
    LINK_UP    = 3'b100
  } link_state_e;

endpackage

// file: verilog/disagree_timer.sv
// Discrepancy timer for one redundant channel pair.
// Assumes both channels are already synchronised to pclk.
`timescale 1ns/1ps
module disagree_timer
  import interlock_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic chan_a,
  input  wire logic chan_b,
  output logic      fault
);

  logic [TIMER_W-1:0] count_q;
  logic [TIMER_W-1:0] count_d;
  logic               fault_q;
  wire                differ = chan_a ^ chan_b;
  wire                expired = (count_q >= TIMER_W'(DISAGREE_CYCLES - 1));

  // The count restarts whenever the pair agrees, so only a lasting split trips.
  assign count_d = !differ ? '0 : (expired ? count_q : count_q + 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      fault_q <= 1'b0;
    end else begin
      count_q <= count_d;
      fault_q <= differ && expired;
    end
  end

  assign fault = fault_q;

endmodule

// file: verilog/safety_interlock_monitor.sv
// Safety interlock monitor: dual-channel checks, latches, emergency stop and APB registers.
// Assumes field inputs are asynchronous levels and software drives the reset command.
//
// Operation
// - No pendant nor bypass forces emergency stop.
// - Pendant link comes up automatically on presence.
// - Pendant removed in manual keeps manual mode.
// - Safeguard channels split two seconds: critical error.
// - Open safeguard holds program, prohibits power.
// - Latch safeguard-open and manual-mode until acknowledged.
// - Open release keeps latches; closing clears.
// - Cleared jog latch, open guard: still prohibited.
// - Emergency circuits split two seconds: critical error.
// - Active stop lights halt indicator, reports status.
// - Leave stop only after release plus reset.
// - Empty safety connector blocks normal operation.
// - Switch contacts split two seconds: critical error.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module safety_interlock_monitor
  import interlock_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        guard_a,
  input  wire logic        guard_b,
  input  wire logic        ckt_a,
  input  wire logic        ckt_b,
  input  wire logic        sw_a,
  input  wire logic        sw_b,
  input  wire logic        latch_release,
  input  wire logic        pendant_present,
  input  wire logic        bypass_plug,
  input  wire logic        mode_manual,
  input  wire logic        connector_present,
  output logic             halt_indicator,
  output logic             estop_status,
  output logic             power_prohibit,
  output logic             program_hold,
  output logic             critical_error,
  output logic             link_enable,
  output logic             irq
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Guard and stop channels are high when closed (safe).
  field_in_s raw;
  field_in_s sync1_q;
  field_in_s in_q;

  // Fields are named so that a reordered struct cannot swap two channels.
  assign raw = '{guard_a:           guard_a,
                 guard_b:           guard_b,
                 ckt_a:             ckt_a,
                 ckt_b:             ckt_b,
                 sw_a:              sw_a,
                 sw_b:              sw_b,
                 latch_release:     latch_release,
                 pendant_present:   pendant_present,
                 bypass_plug:       bypass_plug,
                 mode_manual:       mode_manual,
                 connector_present: connector_present};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      in_q    <= '0;
    end else begin
      sync1_q <= raw;
      in_q    <= sync1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Discrepancy timers
  // ---------------------------------------------------------------------------
  // A two-second split is 80 million cycles, far longer than a bench run.
  logic fault_guard;
  logic fault_ckt;
  logic fault_sw;

  disagree_timer u_guard_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .chan_a  (in_q.guard_a),
    .chan_b  (in_q.guard_b),
    .fault   (fault_guard)
  );

  disagree_timer u_ckt_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .chan_a  (in_q.ckt_a),
    .chan_b  (in_q.ckt_b),
    .fault   (fault_ckt)
  );

  disagree_timer u_sw_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .chan_a  (in_q.sw_a),
    .chan_b  (in_q.sw_b),
    .fault   (fault_sw)
  );

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_st   = (paddr == OFS_STATE);
  wire hit_ev   = (paddr == OFS_EVENT);
  wire hit_en   = (paddr == OFS_ENABLE);
  wire hit_clr  = (paddr == OFS_CLEAR);
  wire mapped   = hit_ctrl | hit_st | hit_ev | hit_en | hit_clr;
  wire wr_ctrl   = wr && hit_ctrl;
  wire wr_en     = wr && hit_en;
  wire wr_clr    = wr && hit_clr;
  wire rd_setup  = psel && !penable && !pwrite;
  wire reset_cmd = wr_ctrl && pwdata[CTRL_RESET_CMD];
  wire crit_ack  = wr_ctrl && pwdata[CTRL_CRIT_ACK];

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // ---------------------------------------------------------------------------
  // Pendant link and mode
  // ---------------------------------------------------------------------------
  link_state_e link_q;
  link_state_e link_d;
  logic        manual_q;

  // Presence alone drives the link; no software set-up is needed.
  always_comb begin
    link_d = link_q;
    case (link_q)
      LINK_IDLE:  link_d = in_q.pendant_present ? LINK_SETUP : LINK_IDLE;
      LINK_SETUP: link_d = in_q.pendant_present ? LINK_UP : LINK_IDLE;
      LINK_UP:    link_d = in_q.pendant_present ? LINK_UP : LINK_IDLE;
      default:    link_d = LINK_IDLE;
    endcase
  end

  // The key is only read while a pendant is plugged; otherwise the mode freezes.
  wire manual_d = in_q.pendant_present ? in_q.mode_manual : manual_q;

  // ---------------------------------------------------------------------------
  // Latches, emergency stop and critical error
  // ---------------------------------------------------------------------------
  logic estop_q;
  logic guard_latch_q;
  logic jog_latch_q;
  logic crit_q;

  wire guard_open  = !(in_q.guard_a && in_q.guard_b);
  wire stop_demand = !(in_q.ckt_a && in_q.ckt_b) || !(in_q.sw_a && in_q.sw_b);
  wire no_pendant  = !in_q.pendant_present && !in_q.bypass_plug;
  wire any_fault   = fault_guard | fault_ckt | fault_sw;

  // Stop is entered by a pressed switch, a missing pendant with no bypass plug, or an empty connector.
  wire estop_set = stop_demand || no_pendant || !in_q.connector_present;
  // Leaving needs the cause gone first; a reset during a press is ignored.
  wire estop_d   = estop_set ? 1'b1 : (reset_cmd ? 1'b0 : estop_q);

  // Set wins over release, so an opening seen while the release is closed still latches.
  wire guard_latch_d = guard_open ? 1'b1 :
                       (in_q.latch_release ? 1'b0 : guard_latch_q);
  wire jog_latch_d   = manual_d ? 1'b1 :
                       (in_q.latch_release ? 1'b0 : jog_latch_q);

  wire crit_d = any_fault ? 1'b1 : (crit_ack ? 1'b0 : crit_q);

  // Reset assumes manual mode until a plugged pendant says otherwise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q   <= LINK_IDLE;
      manual_q <= 1'b1;
    end else begin
      link_q   <= link_d;
      manual_q <= manual_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estop_q       <= 1'b1;
      guard_latch_q <= 1'b1;
      jog_latch_q   <= 1'b1;
      crit_q        <= 1'b0;
    end else begin
      estop_q       <= estop_d;
      guard_latch_q <= guard_latch_d;
      jog_latch_q   <= jog_latch_d;
      crit_q        <= crit_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  logic prohibit_q;
  logic hold_q;

  // The live guard term keeps power off even once the jog latch has gone.
  wire prohibit_d = guard_open || guard_latch_q || jog_latch_q ||
                    estop_d || crit_d;
  wire hold_d     = guard_open || guard_latch_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prohibit_q <= 1'b1;
      hold_q     <= 1'b1;
    end else begin
      prohibit_q <= prohibit_d;
      hold_q     <= hold_d;
    end
  end

  assign halt_indicator = estop_q;
  assign estop_status   = estop_q;
  assign power_prohibit = prohibit_q;
  assign program_hold   = hold_q;
  assign critical_error = crit_q;
  assign link_enable    = (link_q == LINK_UP);

  // ---------------------------------------------------------------------------
  // Interrupt status, enable and clear
  // ---------------------------------------------------------------------------
  logic [EV_W-1:0] event_q;
  logic [EV_W-1:0] enable_q;
  logic            estop_prev_q;
  logic            pendant_prev_q;

  wire [EV_W-1:0] ev_in;
  assign ev_in[EV_ESTOP]   = estop_q && !estop_prev_q;
  assign ev_in[EV_CRIT]    = any_fault;
  assign ev_in[EV_GUARD]   = guard_open;
  assign ev_in[EV_PENDANT] = in_q.pendant_present ^ pendant_prev_q;

  wire [EV_W-1:0] clr_bits = wr_clr ? pwdata[EV_W-1:0] : '0;
  // Hardware set beats a software clear in the same cycle.
  wire [EV_W-1:0] event_d  = ev_in | (event_q & ~clr_bits);
  wire [EV_W-1:0] enable_d = wr_en ? pwdata[EV_W-1:0] : enable_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q  <= '0;
      enable_q <= '0;
    end else begin
      event_q  <= event_d;
      enable_q <= enable_d;
    end
  end

  // The edge trackers reset to the levels that their sources reset to.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estop_prev_q   <= 1'b1;
      pendant_prev_q <= 1'b0;
    end else begin
      estop_prev_q   <= estop_q;
      pendant_prev_q <= in_q.pendant_present;
    end
  end

  assign irq = |(event_q & enable_q);

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  wire [ST_W-1:0] state_word = {link_enable, manual_q, in_q.pendant_present,
                                fault_sw, fault_ckt, fault_guard, hold_q,
                                prohibit_q, jog_latch_q, guard_latch_q,
                                halt_indicator, estop_q};

  wire [31:0] rd_mux = hit_st  ? {{(32 - ST_W){1'b0}}, state_word} :
                       hit_ev  ? {{(32 - EV_W){1'b0}}, event_q} :
                       hit_en  ? {{(32 - EV_W){1'b0}}, enable_q} :
                       hit_ctrl ? {31'h0000_0000, crit_q} : RESET_WORD;

  logic [31:0] prdata_q;

  // Read data is registered at the setup cycle so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= RESET_WORD;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;

endmodule

// file: test/interlock_chk.sv
// Port-level checks for the safety interlock monitor.
// Assumes one pclk domain with presetn as its asynchronous active-low reset.
`timescale 1ns/1ps
module interlock_chk
  import interlock_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        guard_a,
  input wire logic        guard_b,
  input wire logic        ckt_a,
  input wire logic        ckt_b,
  input wire logic        sw_a,
  input wire logic        sw_b,
  input wire logic        pendant_present,
  input wire logic        bypass_plug,
  input wire logic        connector_present,
  input wire logic        halt_indicator,
  input wire logic        estop_status,
  input wire logic        power_prohibit,
  input wire logic        critical_error,
  input wire logic        link_enable
);
  // --------------------------------------------------------------
  // Helpers and assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One count for all pairs can only run ahead of each pair's own timer, never behind.
  logic [31:0] split_q;
  wire logic   split = (guard_a ^ guard_b) | (ckt_a ^ ckt_b) | (sw_a ^ sw_b);
  wire logic   cmd_wr = psel & penable & pwrite & (paddr == OFS_CTRL) & pwdata[CTRL_RESET_CMD];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      split_q <= 32'h0;
    end else begin
      split_q <= split ? split_q + 32'h1 : 32'h0;
    end
  end
  a_halt_mirror: assert property (halt_indicator == estop_status)
    else $error("halt indicator differs from stop status");
  a_pendant_stop: assert property (
    (!pendant_present && !bypass_plug)[*5] |-> estop_status) else $error("empty port, no stop");
  a_press_stop: assert property (
    (!ckt_a && !ckt_b)[*5] |-> estop_status && halt_indicator) else $error("pressed, no stop");
  a_stop_exit: assert property ($fell(estop_status) |->
    $past(cmd_wr) || $past(cmd_wr, 2) || $past(cmd_wr, 3) || $past(cmd_wr, 4))
    else $error("stop left without reset command");
  a_guard_prohibit: assert property (
    (!guard_a && !guard_b)[*6] |-> power_prohibit) else $error("open guard, power allowed");
  a_open_keeps: assert property ($fell(power_prohibit) |-> $past(guard_a && guard_b, 3))
    else $error("power allowed with guard open");
  a_crit_slow: assert property (
    !critical_error && split_q < 32'h3E8 |=> !critical_error)
    else $error("critical error after a short split");
  a_link_up: assert property (pendant_present[*8] |-> link_enable)
    else $error("pendant link not up");
  a_no_conn: assert property ((!connector_present)[*6] |-> power_prohibit)
    else $error("empty connector, power allowed");
  c_stop_exit: cover property ($fell(estop_status));
  c_power_on: cover property ($fell(power_prohibit));
  c_link: cover property ($rose(link_enable));
endmodule

bind safety_interlock_monitor interlock_chk interlock_chk_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .guard_a, .guard_b,
  .ckt_a, .ckt_b, .sw_a, .sw_b, .pendant_present, .bypass_plug, .connector_present,
  .halt_indicator, .estop_status, .power_prohibit, .critical_error, .link_enable);

// file: test/field_side.sv
// Operator side: safety switches, pendant and latch-release contact.
// Assumes the bench sets the wanted levels just after a rising pclk edge.
`timescale 1ns/1ps
module field_side
  import interlock_pkg::*;
(
  input  wire logic      pclk,
  input  wire field_in_s want,
  output field_in_s      fld
);
  // --------------------------------------------------------------
  // Switch levels
  // --------------------------------------------------------------
  // The release contact waits a cycle for guard_a to settle and stays open while the mode key reads manual.
  field_in_s fld_q = 11'h7F9;
  field_in_s fld_d;
  wire logic rel_ok = !fld_q.mode_manual && (fld_q.guard_a == want.guard_a);
  always_comb begin
    fld_d               = want;
    fld_d.latch_release = want.latch_release && rel_ok;
  end
  always @(posedge pclk) begin
    fld_q <= fld_d;
  end
  assign fld = fld_q;
endmodule

// file: test/safety_interlock_monitor_bench.sv
// Self-checking bench: APB master, operator-side model and the monitor.
// Assumes a 40 MHz pclk and waits that cover the two-stage input sync.
`timescale 1ns/1ps
module safety_interlock_monitor_bench;
  import interlock_pkg::*;
  // --------------------------------------------------------------
  // Stimulus, tasks and tests
  // --------------------------------------------------------------
  // Masks in field_in_s order; IDLE is all closed, pendant in, auto mode.
  localparam logic [10:0] IDLE = 11'h7F9;
  localparam logic [10:0] GUARD = 11'h600;
  localparam logic [10:0] STOP = 11'h1E0;
  localparam logic [10:0] REL = 11'h010;
  localparam logic [10:0] PEND = 11'h008;
  localparam logic [10:0] BYP = 11'h004;
  localparam logic [10:0] MAN = 11'h002;
  localparam logic [10:0] CONN = 11'h001;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, v;
  logic        pready, pslverr, err, halt_indicator, estop_status, power_prohibit;
  logic        program_hold, critical_error, link_enable, irq;
  field_in_s   want = IDLE;
  field_in_s   fld;
  int          errors = 0;
  int          n_compared = 0;
  initial forever #12.5 pclk = ~pclk;
  safety_interlock_monitor safety_interlock_monitor_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .guard_a(fld.guard_a), .guard_b(fld.guard_b), .ckt_a(fld.ckt_a), .ckt_b(fld.ckt_b),
    .sw_a(fld.sw_a), .sw_b(fld.sw_b), .latch_release(fld.latch_release),
    .pendant_present(fld.pendant_present), .bypass_plug(fld.bypass_plug),
    .mode_manual(fld.mode_manual), .connector_present(fld.connector_present),
    .halt_indicator, .estop_status, .power_prohibit, .program_hold, .critical_error,
    .link_enable, .irq);
  field_side field_side_inst (.pclk, .want, .fld);
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input logic [10:0] clr, set, input int n);
    want <= (want & ~clr) | set;
    wt(n);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    wt(1);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    v = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    wt(1);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, e);
    apb(1'h0, a, 32'h0);
    chk(nm, v & m, e);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    wt(20000);
    errors++;
    tally_and_finish();
  end
  initial begin
    wt(5);
    presetn <= 1'h1;
    chk("halt", halt_indicator, 1'h1);
    rdchk("enable", OFS_ENABLE, 32'hF, 32'h0);
    rdchk("hole", 12'h020, 32'hFFFFFFFF, 32'h0);
    chk("slverr", err, 1'h1);
    $display("done: reset");
    wt(12);
    chk("link", link_enable, 1'h1);
    chk("estop", estop_status, 1'h1);
    apb(1'h1, OFS_CTRL, 32'h1);
    wt(4);
    chk("halt", halt_indicator, 1'h0);
    rdchk("state", OFS_STATE, 32'hFFF, 32'hA00);
    $display("done: start");
    apb(1'h1, OFS_CLEAR, 32'hF);
    apb(1'h1, OFS_ENABLE, 32'h4);
    chk("irq", irq, 1'h0);
    step(GUARD | REL, 11'h0, 10);
    chk("hold", program_hold, 1'h1);
    chk("irq", irq, 1'h1);
    step(11'h0, GUARD, 10);
    chk("prohibit", power_prohibit, 1'h1);
    apb(1'h1, OFS_CLEAR, 32'hF);
    chk("irq", irq, 1'h0);
    step(11'h0, REL, 10);
    chk("prohibit", power_prohibit, 1'h0);
    step(GUARD, MAN, 10);
    step(MAN, 11'h0, 10);
    rdchk("latches", OFS_STATE, 32'hC, 32'h4);
    chk("prohibit", power_prohibit, 1'h1);
    $display("done: latches");
    step(STOP | GUARD, GUARD, 10);
    chk("halt", halt_indicator, 1'h1);
    apb(1'h1, OFS_CTRL, 32'h1);
    step(11'h0, STOP, 10);
    chk("estop", estop_status, 1'h1);
    apb(1'h1, OFS_CTRL, 32'h1);
    wt(4);
    chk("halt", halt_indicator, 1'h0);
    $display("done: stop");
    step(11'h0, MAN, 10);
    step(PEND, 11'h0, 10);
    chk("estop", estop_status, 1'h1);
    step(MAN, BYP, 10);
    rdchk("manual", OFS_STATE, 32'h400, 32'h400);
    step(11'h0, PEND, 12);
    chk("link", link_enable, 1'h1);
    apb(1'h1, OFS_CTRL, 32'h1);
    wt(4);
    chk("prohibit", power_prohibit, 1'h0);
    step(CONN, 11'h0, 10);
    chk("prohibit", power_prohibit, 1'h1);
    step(11'h540, CONN, 300);
    rdchk("faults", OFS_STATE, 32'h1C0, 32'h0);
    step(11'h0, 11'h540, 10);
    chk("critical", critical_error, 1'h0);
    $display("done: faults");
    tally_and_finish();
  end
endmodule
